// file: mmd_pkg.sv
/*
 memory map decoder package: boundaries, control bit positions, target codes.
 assumes a 24-bit word address per space and a 10 MHz core clock.
*/
package mmd_pkg;
   localparam int ADDR_W = 24;
   localparam int WORD_W = 24;
   localparam int HALF_W = 16;
   localparam int BANK_W = 8;
   localparam int BANK_IDX_W = 7;
   // ----------------------------------------
   // control bit positions
   // ----------------------------------------
   localparam int OMR_MS_POS = 7;
   localparam int SR_SC_POS = 13;
   localparam int SR_CE_POS = 19;
   // ----------------------------------------
   // program space boundaries
   // ----------------------------------------
   localparam logic [23:0] P_EXT_MS0 = 24'h005000;
   localparam logic [23:0] P_EXT_MS1 = 24'h006000;
   localparam logic [23:0] P_CACHE_MS0 = 24'h004C00;
   localparam logic [23:0] P_CACHE_MS1 = 24'h005C00;
   localparam logic [23:0] P_BOOT_LO = 24'hFF0000;
   localparam logic [23:0] P_BOOT_HI = 24'hFF00BF;
   // ----------------------------------------
   // data space boundaries
   // ----------------------------------------
   localparam logic [23:0] D_EXT_MS0 = 24'h001C00;
   localparam logic [23:0] D_EXT_MS1 = 24'h001400;
   localparam logic [23:0] D_RSV_LO = 24'hFF0000;
   localparam logic [23:0] D_RSV_HI = 24'hFFEFFF;
   localparam logic [23:0] D_IO_LO = 24'hFFFF80;
   localparam logic [23:0] D_IO_LO16 = 24'h00FF80;
   localparam logic [23:0] ADDR_MAX16 = 24'h00FFFF;
   // banks of data ram that live in program space when switched
   localparam logic [6:0] P_BANKS = 7'h50;
   localparam logic [6:0] D_BANKS_SW = 7'h14;
   localparam logic [6:0] SW_BANKS = 7'h08;
   localparam logic [17:0] EXT_MASK18 = 18'h3FFFF;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MMD_SP_P,
      MMD_SP_X,
      MMD_SP_Y
   } mmd_space_t;
   typedef enum logic [2:0] {
      MMD_T_NONE,
      MMD_T_RAM,
      MMD_T_BOOT,
      MMD_T_IO,
      MMD_T_EXT,
      MMD_T_RSV
   } mmd_target_t;
endpackage : mmd_pkg

// file: mmd_cfg_if.sv
/*
 interface carrying the three map control bits between decoder modules.
 assumes the producing module registers the bits.
*/
`timescale 1ns/1ps
`default_nettype none
interface mmd_cfg_if;
   logic ms;
   logic ce;
   logic sc;
   modport src (output ms, output ce, output sc);
   modport dst (input ms, input ce, input sc);
endinterface : mmd_cfg_if
`default_nettype wire

// file: mmd_space_dec.sv
/*
 one-space combinational address decoder, instanced per access path.
 assumes cfg bits stable during an access; the core keeps accesses clear during switches.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_space_dec #(
   parameter mmd_pkg::mmd_space_t SPACE = mmd_pkg::MMD_SP_P
) (
   // config
   mmd_cfg_if.dst cfg,
   // access
   input wire logic [mmd_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_req,
   // result
   output mmd_pkg::mmd_target_t o_target,
   output logic [mmd_pkg::BANK_IDX_W-1:0] o_bank,
   output logic [mmd_pkg::BANK_W-1:0] o_offset
);
   logic [23:0] ext_lo;
   logic [23:0] a;
   logic in_cache;
   logic over16;
   always_comb begin
      // compat mode limits the address to 16 bits; above that is out of map
      over16 = cfg.sc && (i_addr > mmd_pkg::ADDR_MAX16); // [RULE19]
      a = i_addr;
      o_bank = i_addr[mmd_pkg::BANK_W+mmd_pkg::BANK_IDX_W-1:mmd_pkg::BANK_W]; // [RULE8] [RULE22]
      o_offset = i_addr[mmd_pkg::BANK_W-1:0];
      in_cache = 1'b0;
      o_target = mmd_pkg::MMD_T_NONE;
      if (SPACE == mmd_pkg::MMD_SP_P) begin
         ext_lo = cfg.ms ? mmd_pkg::P_EXT_MS1 : mmd_pkg::P_EXT_MS0; // [RULE2] [RULE3]
         // cache steals the top 1 K of program ram
         in_cache = cfg.ce && (a >= (cfg.ms ? mmd_pkg::P_CACHE_MS1
                                            : mmd_pkg::P_CACHE_MS0)); // [RULE4] [RULE5] [RULE6] [RULE21]
      end else begin
         ext_lo = cfg.ms ? mmd_pkg::D_EXT_MS1 : mmd_pkg::D_EXT_MS0; // [RULE9] [RULE10]
      end
      if (!i_req) begin
         o_target = mmd_pkg::MMD_T_NONE;
      end else if (over16) begin
         o_target = mmd_pkg::MMD_T_RSV;
      end else if (SPACE == mmd_pkg::MMD_SP_P) begin
         if (a >= mmd_pkg::P_BOOT_LO && a <= mmd_pkg::P_BOOT_HI) begin
            o_target = mmd_pkg::MMD_T_BOOT; // [RULE7]
         end else if (a > mmd_pkg::P_BOOT_HI) begin
            o_target = mmd_pkg::MMD_T_RSV;
         end else if (a < ext_lo && !in_cache) begin
            o_target = mmd_pkg::MMD_T_RAM; // [RULE23]
         end else begin
            o_target = mmd_pkg::MMD_T_EXT; // [RULE6]
         end
      end else begin
         if (SPACE == mmd_pkg::MMD_SP_X && !cfg.sc && a >= mmd_pkg::D_IO_LO) begin
            o_target = mmd_pkg::MMD_T_IO; // [RULE11] [RULE12]
         end else if (SPACE == mmd_pkg::MMD_SP_X && cfg.sc && a >= mmd_pkg::D_IO_LO16) begin
            o_target = mmd_pkg::MMD_T_IO; // [RULE11]
         end else if (a >= mmd_pkg::D_RSV_LO && a <= mmd_pkg::D_RSV_HI) begin
            o_target = mmd_pkg::MMD_T_RSV;
         end else if (a < ext_lo) begin
            o_target = mmd_pkg::MMD_T_RAM; // [RULE8]
         end else begin
            // y top window falls through to the external port [RULE13]
            o_target = mmd_pkg::MMD_T_EXT;
         end
      end
   end
endmodule : mmd_space_dec
`default_nettype wire

// file: mmd_map_decoder.sv
/*
 internal memory map decoder: holds switch, cache and compat bits, decodes
 program, x and y accesses to one target each, and maps switched banks.
 assumes the core writes the mode bits through the write strobes below and
 respects the switching sequence; registered outputs lag the request one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: mode register bit 7 is memory switch
// RULE2: switch clear: 20K program, external from 5000
// RULE3: switch set: 24K program, external from 6000
// RULE4: cache on, switch clear: 19K program
// RULE5: cache on, switch set: 23K program
// RULE6: cache 1K not addressable, goes external
// RULE7: FF0000..FF00BF selects 192-word boot rom
// RULE8: x and y ram 7K, 28 banks
// RULE9: x external from 1C00 or 1400
// RULE10: y external from 1C00 or 1400
// RULE11: top 128 x addresses are register window
// RULE12: register window reachable by all move kinds
// RULE13: off-chip peripherals belong in top y
// RULE14: software avoids reserved ranges
// RULE15: software clears cache before toggling switch
// RULE16: no accesses to affected ranges mid-switch
// RULE17: avoid stepping switch from debug port
// RULE18: status bit 13 compat, reset clear
// RULE19: compat limits to FFFF, 16-bit words
// RULE20: external reach 64K/256K/4M words
// RULE21: cache at 4C00 or 5C00 range
// RULE22: 80 program banks, eight x/y switched
// RULE23: one target select per access
module mmd_map_decoder #(
   parameter int EXT_ADDR_W = 18,
   parameter int ATTR_W = 4
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // mode register writes from the core
   input wire logic i_omr_we,
   input wire logic [mmd_pkg::WORD_W-1:0] i_omr_wdata,
   input wire logic i_sr_we,
   input wire logic [mmd_pkg::WORD_W-1:0] i_sr_wdata,
   // program access
   input wire logic i_p_req,
   input wire logic [mmd_pkg::ADDR_W-1:0] i_p_addr,
   // x access
   input wire logic i_x_req,
   input wire logic [mmd_pkg::ADDR_W-1:0] i_x_addr,
   // y access
   input wire logic i_y_req,
   input wire logic [mmd_pkg::ADDR_W-1:0] i_y_addr,
   // mode state
   output logic o_memory_switch_bit,
   output logic o_cache_en,
   output logic o_sixteen_bit_compat_bit,
   output logic [mmd_pkg::WORD_W-1:0] o_word_mask,
   // combinational selects
   output mmd_pkg::mmd_target_t o_p_target,
   output mmd_pkg::mmd_target_t o_x_target,
   output mmd_pkg::mmd_target_t o_y_target,
   // registered physical bank selects
   output logic [mmd_pkg::BANK_IDX_W-1:0] o_p_bank,
   output logic [mmd_pkg::BANK_IDX_W-1:0] o_x_bank,
   output logic [mmd_pkg::BANK_IDX_W-1:0] o_y_bank,
   output logic o_p_bank_from_x,
   output logic o_p_bank_from_y,
   output logic [mmd_pkg::BANK_W-1:0] o_p_offset,
   output logic [mmd_pkg::BANK_W-1:0] o_x_offset,
   output logic [mmd_pkg::BANK_W-1:0] o_y_offset,
   // registered external port address
   output logic o_ext_valid,
   output mmd_pkg::mmd_space_t o_ext_space,
   output logic [EXT_ADDR_W-1:0] o_ext_addr,
   output logic [ATTR_W-1:0] o_ext_attr
);
   // ----------------------------------------
   // mode bits
   // ----------------------------------------
   logic ms_r, ms_nxt;
   logic ce_r, ce_nxt;
   logic sc_r, sc_nxt;
   always_comb begin
      ms_nxt = ms_r;
      ce_nxt = ce_r;
      sc_nxt = sc_r;
      if (i_omr_we) begin
         ms_nxt = i_omr_wdata[mmd_pkg::OMR_MS_POS]; // [RULE1]
      end
      if (i_sr_we) begin
         ce_nxt = i_sr_wdata[mmd_pkg::SR_CE_POS];
         sc_nxt = i_sr_wdata[mmd_pkg::SR_SC_POS]; // [RULE18]
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ms_r <= 1'b0;
         ce_r <= 1'b0;
         sc_r <= 1'b0; // [RULE18]
      end else begin
         ms_r <= ms_nxt;
         ce_r <= ce_nxt;
         sc_r <= sc_nxt;
      end
   end
   assign o_memory_switch_bit = ms_r;
   assign o_cache_en = ce_r;
   assign o_sixteen_bit_compat_bit = sc_r;
   // compat mode narrows every word to 16 bits
   assign o_word_mask = sc_r ? {{(mmd_pkg::WORD_W-mmd_pkg::HALF_W){1'b0}},
                                {mmd_pkg::HALF_W{1'b1}}}
                             : {mmd_pkg::WORD_W{1'b1}}; // [RULE19]
   // ----------------------------------------
   // per-space decode
   // ----------------------------------------
   mmd_cfg_if cfg ();
   assign cfg.ms = ms_r;
   assign cfg.ce = ce_r;
   assign cfg.sc = sc_r;
   logic [mmd_pkg::BANK_IDX_W-1:0] p_bank_c, x_bank_c, y_bank_c;
   logic [mmd_pkg::BANK_W-1:0] p_off_c, x_off_c, y_off_c;
   mmd_space_dec #(.SPACE(mmd_pkg::MMD_SP_P)) u_p_dec (
      .cfg(cfg.dst),
      .i_addr(i_p_addr),
      .i_req(i_p_req),
      .o_target(o_p_target),
      .o_bank(p_bank_c),
      .o_offset(p_off_c)
   );
   mmd_space_dec #(.SPACE(mmd_pkg::MMD_SP_X)) u_x_dec (
      .cfg(cfg.dst),
      .i_addr(i_x_addr),
      .i_req(i_x_req),
      .o_target(o_x_target),
      .o_bank(x_bank_c),
      .o_offset(x_off_c)
   );
   mmd_space_dec #(.SPACE(mmd_pkg::MMD_SP_Y)) u_y_dec (
      .cfg(cfg.dst),
      .i_addr(i_y_addr),
      .i_req(i_y_req),
      .o_target(o_y_target),
      .o_bank(y_bank_c),
      .o_offset(y_off_c)
   );
   // ----------------------------------------
   // bank steering and external address
   // ----------------------------------------
   // program banks 80..95 are physically the top eight x then top eight y banks
   logic [6:0] p_bank_nxt, p_bank_r, x_bank_r, y_bank_r;
   logic from_x_nxt, from_x_r, from_y_nxt, from_y_r;
   logic [7:0] p_off_r, x_off_r, y_off_r;
   logic ext_v_nxt, ext_v_r;
   mmd_pkg::mmd_space_t ext_sp_nxt, ext_sp_r;
   logic [mmd_pkg::ADDR_W-1:0] ext_full;
   logic [EXT_ADDR_W-1:0] ext_a_nxt, ext_a_r;
   logic [ATTR_W-1:0] ext_t_nxt, ext_t_r;
   always_comb begin
      p_bank_nxt = p_bank_c;
      from_x_nxt = 1'b0;
      from_y_nxt = 1'b0;
      if (o_p_target == mmd_pkg::MMD_T_RAM && p_bank_c >= mmd_pkg::P_BANKS) begin
         if (p_bank_c < 7'(mmd_pkg::P_BANKS + mmd_pkg::SW_BANKS)) begin
            from_x_nxt = 1'b1; // [RULE22]
            p_bank_nxt = 7'(p_bank_c - mmd_pkg::P_BANKS + mmd_pkg::D_BANKS_SW);
         end else begin
            from_y_nxt = 1'b1; // [RULE22]
            p_bank_nxt = 7'(p_bank_c - mmd_pkg::P_BANKS - mmd_pkg::SW_BANKS
                            + mmd_pkg::D_BANKS_SW);
         end
      end
      // program has priority on the shared external port, then x, then y
      ext_v_nxt = 1'b1;
      ext_sp_nxt = mmd_pkg::MMD_SP_P;
      ext_full = i_p_addr;
      if (o_p_target == mmd_pkg::MMD_T_EXT) begin
         ext_sp_nxt = mmd_pkg::MMD_SP_P;
      end else if (o_x_target == mmd_pkg::MMD_T_EXT) begin
         ext_sp_nxt = mmd_pkg::MMD_SP_X;
         ext_full = i_x_addr;
      end else if (o_y_target == mmd_pkg::MMD_T_EXT) begin
         ext_sp_nxt = mmd_pkg::MMD_SP_Y;
         ext_full = i_y_addr;
      end else begin
         ext_v_nxt = 1'b0;
      end
      // 18 lines plus four attribute lines; compat mode stays within 64 K
      ext_a_nxt = ext_full[EXT_ADDR_W-1:0]; // [RULE20]
      ext_t_nxt = sc_r ? '0 : ext_full[EXT_ADDR_W+ATTR_W-1:EXT_ADDR_W]; // [RULE20]
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         p_bank_r <= '0;
         x_bank_r <= '0;
         y_bank_r <= '0;
         from_x_r <= 1'b0;
         from_y_r <= 1'b0;
         p_off_r <= '0;
         x_off_r <= '0;
         y_off_r <= '0;
         ext_v_r <= 1'b0;
         ext_sp_r <= mmd_pkg::MMD_SP_P;
         ext_a_r <= '0;
         ext_t_r <= '0;
      end else begin
         p_bank_r <= p_bank_nxt;
         x_bank_r <= x_bank_c;
         y_bank_r <= y_bank_c;
         from_x_r <= from_x_nxt;
         from_y_r <= from_y_nxt;
         p_off_r <= p_off_c;
         x_off_r <= x_off_c;
         y_off_r <= y_off_c;
         ext_v_r <= ext_v_nxt;
         ext_sp_r <= ext_sp_nxt;
         ext_a_r <= ext_a_nxt;
         ext_t_r <= ext_t_nxt;
      end
   end
   assign o_p_bank = p_bank_r;
   assign o_x_bank = x_bank_r;
   assign o_y_bank = y_bank_r;
   assign o_p_bank_from_x = from_x_r;
   assign o_p_bank_from_y = from_y_r;
   assign o_p_offset = p_off_r;
   assign o_x_offset = x_off_r;
   assign o_y_offset = y_off_r;
   assign o_ext_valid = ext_v_r;
   assign o_ext_space = ext_sp_r;
   assign o_ext_addr = ext_a_r;
   assign o_ext_attr = ext_t_r;
endmodule : mmd_map_decoder
`default_nettype wire

// file: mmd_map_decoder_chk.sv
/*
 checker for the map decoder: mode loads, decode boundaries, bank remap.
 assumes it is bound to mmd_map_decoder and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_map_decoder_chk (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // mode writes
   input wire logic i_omr_we,
   input wire logic [23:0] i_omr_wdata,
   input wire logic i_sr_we,
   input wire logic [23:0] i_sr_wdata,
   // accesses
   input wire logic i_p_req,
   input wire logic [23:0] i_p_addr,
   input wire logic i_x_req,
   input wire logic [23:0] i_x_addr,
   input wire logic i_y_req,
   input wire logic [23:0] i_y_addr,
   // decoder outputs
   input wire logic o_memory_switch_bit,
   input wire logic o_cache_en,
   input wire logic o_sixteen_bit_compat_bit,
   input wire mmd_pkg::mmd_target_t o_p_target,
   input wire mmd_pkg::mmd_target_t o_x_target,
   input wire mmd_pkg::mmd_target_t o_y_target,
   input wire logic o_p_bank_from_x,
   input wire logic o_ext_valid
);
   wire logic sc = o_sixteen_bit_compat_bit;
   wire logic [23:0] p_ext = o_memory_switch_bit ? 24'h006000 : 24'h005000;
   wire logic [23:0] p_ram = p_ext - (o_cache_en ? 24'h000400 : 24'h000000);
   wire logic [23:0] d_ext = o_memory_switch_bit ? 24'h001400 : 24'h001C00;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   property p_rst_clr;
      disable iff (1'b0) i_reset |=> !o_memory_switch_bit && !o_cache_en && !sc;
   endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("mode bits not cleared");
   property p_ms_load;
      i_omr_we |=> o_memory_switch_bit == $past(i_omr_wdata[7]);
   endproperty
   a_ms_load: assert property (p_ms_load) else $error("switch bit not loaded");
   property p_sr_load;
      i_sr_we |=> sc == $past(i_sr_wdata[13]) && o_cache_en == $past(i_sr_wdata[19]);
   endproperty
   a_sr_load: assert property (p_sr_load) else $error("status bits not loaded");
   property p_p_ram;
      i_p_req && i_p_addr < p_ram |-> o_p_target == mmd_pkg::MMD_T_RAM;
   endproperty
   a_p_ram: assert property (p_p_ram) else $error("program ram miss");
   property p_p_ext;
      i_p_req && i_p_addr >= p_ram && i_p_addr < 24'h008000 |-> o_p_target == mmd_pkg::MMD_T_EXT;
   endproperty
   a_p_ext: assert property (p_p_ext) else $error("program ext miss");
   property p_boot;
      i_p_req && !sc && i_p_addr inside {[24'hFF0000:24'hFF00BF]} |->
         o_p_target == mmd_pkg::MMD_T_BOOT;
   endproperty
   a_boot: assert property (p_boot) else $error("boot rom miss");
   property p_x_map;
      i_x_req && i_x_addr < 24'h008000 |->
         o_x_target == (i_x_addr < d_ext ? mmd_pkg::MMD_T_RAM : mmd_pkg::MMD_T_EXT);
   endproperty
   a_x_map: assert property (p_x_map) else $error("x data split wrong");
   property p_y_map;
      i_y_req && i_y_addr < 24'h008000 |->
         o_y_target == (i_y_addr < d_ext ? mmd_pkg::MMD_T_RAM : mmd_pkg::MMD_T_EXT);
   endproperty
   a_y_map: assert property (p_y_map) else $error("y data split wrong");
   property p_x_io;
      i_x_req && i_x_addr[23:7] == (sc ? 17'h001FF : 17'h1FFFF) |->
         o_x_target == mmd_pkg::MMD_T_IO;
   endproperty
   a_x_io: assert property (p_x_io) else $error("x io window miss");
   property p_sc_lim;
      i_x_req && sc && i_x_addr > 24'h00FFFF |-> o_x_target == mmd_pkg::MMD_T_RSV;
   endproperty
   a_sc_lim: assert property (p_sc_lim) else $error("compat limit broken");
   property p_one_tgt;
      i_p_req |-> o_p_target inside {[mmd_pkg::MMD_T_RAM:mmd_pkg::MMD_T_RSV]};
   endproperty
   a_one_tgt: assert property (p_one_tgt) else $error("no program target");
   property p_remap;
      i_p_req && o_memory_switch_bit && i_p_addr[23:8] == 16'h0050 |=> o_p_bank_from_x;
   endproperty
   a_remap: assert property (p_remap) else $error("switched bank not in x");
   property p_ext_go;
      i_p_req && o_p_target == mmd_pkg::MMD_T_EXT |=> o_ext_valid;
   endproperty
   a_ext_go: assert property (p_ext_go) else $error("ext port not used");
   c_sw: cover property (i_p_req && o_memory_switch_bit && o_p_target == mmd_pkg::MMD_T_RAM);
   c_cache: cover property (i_p_req && o_cache_en && o_p_target == mmd_pkg::MMD_T_EXT);
   c_io: cover property (i_x_req && o_x_target == mmd_pkg::MMD_T_IO);
endmodule : mmd_map_decoder_chk
bind mmd_map_decoder mmd_map_decoder_chk u_mmd_map_decoder_chk (.*);
`default_nettype wire

// file: mmd_ext_mem_model.sv
/*
 external memory port model: captures each external access.
 assumes registered decoder port outputs, one access at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_mem_model (
   // clock
   input wire logic i_sys_clk,
   // external port
   input wire logic i_ext_valid,
   input wire mmd_pkg::mmd_space_t i_ext_space,
   input wire logic [17:0] i_ext_addr,
   input wire logic [3:0] i_ext_attr,
   // capture
   output logic o_hit,
   output mmd_pkg::mmd_space_t o_space,
   output logic [21:0] o_addr,
   output logic o_periph
);
   always_ff @(posedge i_sys_clk) begin
      o_hit <= i_ext_valid;
      if (i_ext_valid) begin
         o_space <= i_ext_space;
         o_addr <= {i_ext_attr, i_ext_addr};
         // off-chip peripherals sit in the top 128 y words
         o_periph <= i_ext_space == mmd_pkg::MMD_SP_Y && &i_ext_addr[17:7];
      end
   end
endmodule : mmd_ext_mem_model
`default_nettype wire

// file: test_internal_memory_map_decoder.sv
/*
 testbench for the map decoder: mode writes, decode of all three spaces.
 assumes checker bound separately; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module test_internal_memory_map_decoder;
   localparam mmd_pkg::mmd_space_t P = mmd_pkg::MMD_SP_P, X = mmd_pkg::MMD_SP_X;
   localparam mmd_pkg::mmd_space_t Y = mmd_pkg::MMD_SP_Y;
   localparam mmd_pkg::mmd_target_t RAM = mmd_pkg::MMD_T_RAM, EXT = mmd_pkg::MMD_T_EXT;
   localparam mmd_pkg::mmd_target_t IO = mmd_pkg::MMD_T_IO, RSV = mmd_pkg::MMD_T_RSV;
   logic sys_clk, reset, omr_we, sr_we, p_req, x_req, y_req, ms_o, ce_o, sc_o, from_x;
   logic ext_valid, hit, periph, sc_cur, fx_s, fy_s, from_y;
   logic [6:0] x_bank, y_bank, xyb_s;
   logic [7:0] p_off, x_off, y_off, off_s;
   logic [23:0] omr_wdata, sr_wdata, p_addr, x_addr, y_addr, word_mask, b, top;
   logic [17:0] ext_addr;
   logic [3:0] ext_attr;
   logic [6:0] p_bank, bank_s;
   logic [21:0] cap_addr;
   mmd_pkg::mmd_target_t p_tgt, x_tgt, y_tgt;
   mmd_pkg::mmd_space_t ext_space, cap_space;
   int errors, comparisons, cycles;
   mmd_map_decoder u_mmd_map_decoder (.i_sys_clk(sys_clk), .i_reset(reset),
      .i_omr_we(omr_we), .i_omr_wdata(omr_wdata), .i_sr_we(sr_we), .i_sr_wdata(sr_wdata),
      .i_p_req(p_req), .i_p_addr(p_addr), .i_x_req(x_req), .i_x_addr(x_addr),
      .i_y_req(y_req), .i_y_addr(y_addr), .o_memory_switch_bit(ms_o), .o_cache_en(ce_o),
      .o_sixteen_bit_compat_bit(sc_o), .o_word_mask(word_mask), .o_p_target(p_tgt),
      .o_x_target(x_tgt), .o_y_target(y_tgt), .o_p_bank(p_bank), .o_x_bank(x_bank),
      .o_y_bank(y_bank), .o_p_bank_from_x(from_x), .o_p_bank_from_y(from_y),
      .o_p_offset(p_off), .o_x_offset(x_off), .o_y_offset(y_off),
      .o_ext_valid(ext_valid), .o_ext_space(ext_space),
      .o_ext_addr(ext_addr), .o_ext_attr(ext_attr));
   mmd_ext_mem_model u_mmd_ext_mem_model (.i_sys_clk(sys_clk), .i_ext_valid(ext_valid),
      .i_ext_space(ext_space), .i_ext_addr(ext_addr), .i_ext_attr(ext_attr), .o_hit(hit),
      .o_space(cap_space), .o_addr(cap_addr), .o_periph(periph));
   initial begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // released address lines show the inverse, not the last value
   task automatic acc(input mmd_pkg::mmd_space_t sp, input logic [23:0] a,
                      input mmd_pkg::mmd_target_t t);
      logic [2:0] seen;
      @(negedge sys_clk);
      {p_req, x_req, y_req} = {sp == P, sp == X, sp == Y};
      {p_addr, x_addr, y_addr} = {a, a, a};
      #1;
      seen = sp == P ? p_tgt : (sp == X ? x_tgt : y_tgt);
      check({21'h0, seen}, {21'h0, t});
      @(negedge sys_clk);
      {bank_s, fx_s, fy_s} = {p_bank, from_x, from_y};
      off_s = sp == P ? p_off : (sp == X ? x_off : y_off);
      xyb_s = sp == X ? x_bank : y_bank;
      {p_req, x_req, y_req} = 3'b000;
      {p_addr, x_addr, y_addr} = {~a, ~a, ~a};
      check({16'h0, off_s}, {16'h0, a[7:0]});
      if (sp != P) check({17'h0, xyb_s}, {17'h0, a[14:8]});
      @(negedge sys_clk);
      check({23'h0, hit}, {23'h0, t == EXT});
      if (t == EXT)
         check({cap_space, cap_addr}, {sp, sc_cur ? 4'h0 : a[21:18], a[17:0]});
   endtask : acc
   // cache off before the switch moves, no accesses meanwhile
   task automatic mode(input logic ms, input logic ce, input logic sc);
      @(negedge sys_clk);
      {sr_we, sr_wdata} = {1'b1, 4'h0, 1'b0, 5'h0, sc, 13'h0};
      @(negedge sys_clk);
      {sr_we, omr_we, omr_wdata} = {1'b0, 1'b1, 16'h0, ms, 7'h0};
      @(negedge sys_clk);
      {omr_we, sr_we, sr_wdata} = {1'b0, 1'b1, 4'h0, ce, 5'h0, sc, 13'h0};
      @(negedge sys_clk);
      {sr_we, sc_cur} = {1'b0, sc};
      check({21'h0, ms_o, ce_o, sc_o}, {21'h0, ms, ce, sc});
      check(word_mask, sc ? 24'h00FFFF : 24'hFFFFFF);
   endtask : mode
   task automatic t_reset;
      check({21'h0, ms_o, ce_o, sc_o}, 24'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_prog;
      for (int i = 0; i < 4; i++) begin
         mode(i[1], i[0], 1'b0);
         b = i[1] ? 24'h006000 : 24'h005000;
         top = b - (i[0] ? 24'h000400 : 24'h000000);
         acc(P, top - 24'h1, RAM);
         acc(P, top, EXT);
         acc(P, b, EXT);
      end
      acc(P, 24'h005000, RAM);
      check({15'h0, fx_s, fy_s, bank_s}, {15'h0, 2'b10, 7'h14});
      acc(P, 24'h005800, RAM);
      check({15'h0, fx_s, fy_s, bank_s}, {15'h0, 2'b01, 7'h14});
      $display("program test done");
   endtask : t_prog
   task automatic t_data;
      for (int i = 0; i < 2; i++) begin
         mode(i[0], 1'b0, 1'b0);
         b = i[0] ? 24'h001400 : 24'h001C00;
         acc(X, b - 24'h1, RAM);
         acc(X, b, EXT);
         acc(Y, b - 24'h1, RAM);
         acc(Y, b, EXT);
      end
      $display("data test done");
   endtask : t_data
   task automatic t_special;
      mode(1'b0, 1'b0, 1'b0);
      acc(P, 24'hFF0000, mmd_pkg::MMD_T_BOOT);
      acc(P, 24'hFF00BF, mmd_pkg::MMD_T_BOOT);
      acc(P, 24'hFF00C0, RSV);
      acc(X, 24'hFFFF80, IO);
      acc(X, 24'hFFFFFF, IO);
      acc(X, 24'hFFEFFF, RSV);
      acc(Y, 24'hFFFF80, EXT);
      check({23'h0, periph}, 24'h1);
      acc(Y, 24'h2C1234, EXT);
      mode(1'b0, 1'b0, 1'b1);
      acc(X, 24'h010000, RSV);
      acc(X, 24'h00FF80, IO);
      acc(P, 24'h004FFF, RAM);
      acc(X, 24'h001C00, EXT);
      $display("special test done");
   endtask : t_special
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      {reset, omr_we, sr_we, p_req, x_req, y_req, sc_cur} = 7'h41;
      {omr_wdata, sr_wdata, p_addr, x_addr, y_addr} = '0;
      repeat (16) @(negedge sys_clk);
      reset = 0;
      sc_cur = 0;
      t_reset();
      t_prog();
      t_data();
      t_special();
      stop_test();
   end
endmodule : test_internal_memory_map_decoder
`default_nettype wire
